//--- rtl/clock_fail_monitor_consts.svh
// Numeric constants of the clock fail monitor: offsets, fields, counts.
`ifndef CLOCK_FAIL_MONITOR_CONSTS_SVH
`define CLOCK_FAIL_MONITOR_CONSTS_SVH

// Register indexes; the byte address is four times the index.
`define CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_ENABLE_2 8'h8D
`define CLOCK_FAIL_MONITOR_IDX_OSCILLATOR_CONTROL_REG 8'h8F
`define CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_FLAGS_2 8'hA0
`define CLOCK_FAIL_MONITOR_IDX_CFG 8'hA1
`define CLOCK_FAIL_MONITOR_IDX_PWR 8'hA2

// Bus widths and responses.
`define CLOCK_FAIL_MONITOR_AW 12
`define CLOCK_FAIL_MONITOR_RESP_OKAY 2'h0
`define CLOCK_FAIL_MONITOR_RESP_SLVERR 2'h2

// Field positions.
`define CLOCK_FAIL_MONITOR_BIT_OSF 7
`define CLOCK_FAIL_MONITOR_PERIPHERAL_IRQ_ENABLE_2_LO 4
`define CLOCK_FAIL_MONITOR_PERIPHERAL_IRQ_ENABLE_2_HI 7
`define CLOCK_FAIL_MONITOR_INTERNAL_FREQ_SELECT_LO 4
`define CLOCK_FAIL_MONITOR_INTERNAL_FREQ_SELECT_HI 6
`define CLOCK_FAIL_MONITOR_BIT_STARTUP_TIMEOUT_STATUS 3
`define CLOCK_FAIL_MONITOR_BIT_SCS 0
`define CLOCK_FAIL_MONITOR_BIT_MONEN 0
`define CLOCK_FAIL_MONITOR_MODE_LO 1
`define CLOCK_FAIL_MONITOR_MODE_HI 3
`define CLOCK_FAIL_MONITOR_BIT_SLEEP 0

// Reset values.
`define CLOCK_FAIL_MONITOR_RST_INTERNAL_FREQ_SELECT 3'h6
`define CLOCK_FAIL_MONITOR_RST_PERIPHERAL_IRQ_ENABLE_2 4'h0
`define CLOCK_FAIL_MONITOR_RST_MODE 3'h1

// Sample clock divider: half a sample period is 32 slow oscillator cycles.
`define CLOCK_FAIL_MONITOR_DIV_RATIO 64
`define CLOCK_FAIL_MONITOR_HALF_DIV 5'h1F

// Start-up timer length in external oscillator periods.
`define CLOCK_FAIL_MONITOR_OST_PERIODS 11'h400

`endif

//--- rtl/clock_fail_monitor_pkg.sv
// Types shared by the clock fail monitor modules.
package clock_fail_monitor_pkg;

	// External oscillator modes; the two top codes mean internal only.
	typedef enum logic [2:0] {
		MODE_LP = 3'b000,
		MODE_XT = 3'b001,
		MODE_HS = 3'b010,
		MODE_EC = 3'b011,
		MODE_RC = 3'b100,
		MODE_RESISTOR_CAP_PIN_IO_MODE = 3'b101,
		MODE_INT = 3'b110,
		MODE_INTIO = 3'b111
	} clock_fail_monitor_mode_t;

	// Power and start-up state of the clock source control.
	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_RUN = 2'b01,
		ST_SLEEP = 2'b10
	} clock_fail_monitor_state_t;

	// State of the fail detector.
	typedef struct packed {
		logic lfPrev;
		logic extPrev;
		logic [4:0] divCnt;
		logic sampleClk;
		logic seenRise;
		logic latch;
		logic failPulse;
	} clock_fail_monitor_det_t;

	// State of the top level.
	typedef struct packed {
		clock_fail_monitor_state_t state;
		logic [10:0] ostCnt;
		logic extPrev;
		logic failCond;
		logic oscFailFlag;
		logic [3:0] peripheral_irq_enable_2;
		logic [2:0] internal_freq_select;
		logic system_clock_select;
		logic monEn;
		logic [2:0] mode;
		logic sleepReq;
		logic fs1;
		logic fs2;
		logic awTaken;
		logic [11:0] awAddr;
		logic wTaken;
		logic [7:0] wData;
		logic wStrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} clock_fail_monitor_top_t;

endpackage : clock_fail_monitor_pkg

//--- rtl/clock_fail_monitor_detect.sv
// Fail detector: sample clock divider and the falling edge latch.
`timescale 1ns/100ps
`include "clock_fail_monitor_consts.svh"

module clock_fail_monitor_detect
	import clock_fail_monitor_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Arming from the control logic.
	input wire logic armed,
	// Sampled oscillator levels.
	input wire logic extClk,
	input wire logic lfOsc,
	// One-cycle failure pulse, from a flip-flop.
	output logic failPulse
);

	clock_fail_monitor_det_t s; // Registered detector state.
	clock_fail_monitor_det_t next_s; // Next detector state.
	logic lfRise; // Slow oscillator rising edge.
	logic extFall; // External clock falling edge.

	// Edges are found by comparing each sample with the one before.
	always_comb begin
		next_s = s;
		lfRise = lfOsc && !s.lfPrev;
		extFall = !extClk && s.extPrev;
		next_s.lfPrev = lfOsc;
		next_s.extPrev = extClk;
		next_s.failPulse = 1'b0;
		// The divider runs always; the slow oscillator is free running.
		if (lfRise) begin
			if (s.divCnt == `CLOCK_FAIL_MONITOR_HALF_DIV) begin
				next_s.divCnt = 5'h00;
				next_s.sampleClk = !s.sampleClk;
			end else begin
				next_s.divCnt = s.divCnt + 5'h01;
			end
		end
		if (!armed) begin
			// A disarmed detector forgets history, so a stale latch
			// cannot declare a failure on the first half period.
			next_s.seenRise = 1'b0;
			next_s.latch = 1'b0;
		end else if (next_s.sampleClk && !s.sampleClk) begin
			// Sample rising edge clears the latch; a falling external
			// edge in the same cycle still counts and wins.
			next_s.seenRise = 1'b1;
			next_s.latch = extFall;
		end else if (!next_s.sampleClk && s.sampleClk) begin
			// A whole high half passed with no low-going external edge.
			if (s.seenRise && !s.latch && !extFall) begin
				next_s.failPulse = 1'b1;
			end
			next_s.latch = 1'b0;
		end else if (extFall) begin
			next_s.latch = 1'b1;
		end
	end

	// State register; a low clock enable freezes everything.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign failPulse = s.failPulse;

endmodule : clock_fail_monitor_detect

//--- rtl/clock_fail_monitor_top.sv
// Clock fail monitor top level with its AXI4-Lite register slave.
// Functional notes
// - Monitor works only when enable fuse set.
// - Monitor covers all six external oscillator modes.
// - Detection armed only after start-up timer expires.
// - Sample clock is slow oscillator divided by 64.
// - External clock falling edge sets detector latch.
// - Sample clock rising edge clears detector latch.
// - Fail when half sample period lacks low edge.
// - On fail switch to internal, set flag.
// - Interrupt request when flag and enable set.
// - Stay internal until firmware restarts external oscillator.
// - Fallback frequency from internal frequency select field.
// - Reset, sleep or select toggle clear failure.
// - Select toggle restarts timer, run internal meanwhile.
// - Timer expiry clears failure, external clock resumes.
// - Flag cannot clear while failure still active.
// - Timer after reset/wake, skipped in EC/RC modes.
// - Enabled monitor also enables two-speed start-up.
`timescale 1ns/100ps
`include "clock_fail_monitor_consts.svh"

module clock_fail_monitor_top
	import clock_fail_monitor_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Oscillator levels, sampled on clk.
	input wire logic extClk,
	input wire logic lfOsc,
	// AXI4-Lite write address channel.
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data channel.
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response channel.
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address channel.
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data channel.
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Clock source control toward the clock multiplexer.
	output logic sysClkInternal,
	output logic [2:0] intFreqSel,
	output logic coreHold,
	output logic sleeping,
	// Interrupt request toward the interrupt controller.
	output logic oscFailIrq
);

	clock_fail_monitor_top_t s; // Registered state.
	clock_fail_monitor_top_t next_s; // Next state.
	logic failPulse; // Raw failure pulse from the detector.
	logic extMode; // Selected mode is an external one.
	logic skipOst; // Mode needs no start-up timer.
	logic armed; // Detector armed.
	logic extFall; // External clock falling edge for the timer.
	logic wrGo; // Address and data both held: write now.
	logic [7:0] wrIdx; // Register index of the write.
	logic wrHit; // Write address is mapped.
	logic [7:0] rdIdx; // Register index of the read.
	logic rdHit; // Read address is mapped.
	logic [7:0] rdByte; // Read value before widening.
	logic newScs; // Select bit value carried by a write.

	// Protection bits carry no meaning for this slave.
	logic unusedProt;
	assign unusedProt = ^{awprot, arprot, wstrb[3:1], wdata[31:8]};

	// Mode decode shared by the arming and the start-up logic.
	always_comb begin
		extMode = (s.mode != MODE_INT) && (s.mode != MODE_INTIO);
		skipOst = (s.mode == MODE_EC) || (s.mode == MODE_RC) ||
			(s.mode == MODE_RESISTOR_CAP_PIN_IO_MODE);
		// Only a running, unfailed, external source is watched.
		armed = s.monEn && extMode && (s.state == ST_RUN) &&
			!s.failCond && !s.system_clock_select;
	end

	// The detector sits in its own module so its edges stay local.
	clock_fail_monitor_detect u_detect (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.armed(armed),
		.extClk(extClk),
		.lfOsc(lfOsc),
		.failPulse(failPulse)
	);

	// Handshake outputs are combinational and drop while frozen, so
	// no beat is taken when state cannot move.
	assign awready = ce && !s.awTaken && !s.bvalid;
	assign wready = ce && !s.wTaken && !s.bvalid;
	assign arready = ce && !s.rvalid;

	// Main next-state process: clock control, flags and bus slave.
	always_comb begin
		next_s = s;
		extFall = !extClk && s.extPrev;
		next_s.extPrev = extClk;
		// Two flops carry the failure pulse before it moves the
		// multiplexer; the first is read only by the second.
		next_s.fs1 = failPulse;
		next_s.fs2 = s.fs1;
		wrGo = 1'b0;
		wrIdx = s.awAddr[9:2];
		wrHit = 1'b0;
		rdIdx = araddr[9:2];
		rdHit = 1'b0;
		rdByte = 8'h00;
		newScs = s.wData[`CLOCK_FAIL_MONITOR_BIT_SCS];

		// Start-up, run and sleep sequencing.
		case (s.state)
			ST_START: begin
				if (skipOst || !extMode) begin
					next_s.state = ST_RUN;
					next_s.ostCnt = 11'h000;
				end else if (extFall) begin
					if (s.ostCnt == `CLOCK_FAIL_MONITOR_OST_PERIODS - 11'h001) begin
						// Timer out: failure gone, external runs again.
						next_s.state = ST_RUN;
						next_s.failCond = 1'b0;
						next_s.ostCnt = 11'h000;
					end else begin
						next_s.ostCnt = s.ostCnt + 11'h001;
					end
				end
			end
			ST_RUN: begin
				// A synchronised failure latches until cleared.
				if (s.fs2 && armed) begin
					next_s.failCond = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (!s.sleepReq) begin
					next_s.state = ST_START;
					next_s.ostCnt = 11'h000;
				end
			end
			default: begin
				next_s.state = ST_START;
			end
		endcase
		// Entering sleep clears the failure in every state.
		if (s.sleepReq && (s.state != ST_SLEEP)) begin
			next_s.state = ST_SLEEP;
			next_s.failCond = 1'b0;
		end

		// Write channel: address and data are taken in either order.
		if (awvalid && awready) begin
			next_s.awTaken = 1'b1;
			next_s.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			next_s.wTaken = 1'b1;
			next_s.wData = wdata[7:0];
			next_s.wStrb0 = wstrb[0];
		end
		if (s.awTaken && s.wTaken) begin
			wrGo = 1'b1;
			next_s.awTaken = 1'b0;
			next_s.wTaken = 1'b0;
			next_s.bvalid = 1'b1;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wrGo) begin
			wrHit = (s.awAddr[11:10] == 2'h0) && (s.awAddr[1:0] == 2'h0) &&
				((wrIdx == `CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_ENABLE_2) || (wrIdx == `CLOCK_FAIL_MONITOR_IDX_OSCILLATOR_CONTROL_REG) ||
				(wrIdx == `CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_FLAGS_2) || (wrIdx == `CLOCK_FAIL_MONITOR_IDX_CFG) ||
				(wrIdx == `CLOCK_FAIL_MONITOR_IDX_PWR));
			next_s.bresp = wrHit ? `CLOCK_FAIL_MONITOR_RESP_OKAY : `CLOCK_FAIL_MONITOR_RESP_SLVERR;
		end
		// Only byte lane 0 holds data; other lanes are ignored.
		if (wrGo && wrHit && s.wStrb0) begin
			case (wrIdx)
				`CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_ENABLE_2: begin
					next_s.peripheral_irq_enable_2 = s.wData[`CLOCK_FAIL_MONITOR_PERIPHERAL_IRQ_ENABLE_2_HI:`CLOCK_FAIL_MONITOR_PERIPHERAL_IRQ_ENABLE_2_LO];
				end
				`CLOCK_FAIL_MONITOR_IDX_OSCILLATOR_CONTROL_REG: begin
					// Fallback frequency may be set before any failure.
					next_s.internal_freq_select = s.wData[`CLOCK_FAIL_MONITOR_INTERNAL_FREQ_SELECT_HI:`CLOCK_FAIL_MONITOR_INTERNAL_FREQ_SELECT_LO];
					next_s.system_clock_select = newScs;
					if (newScs != s.system_clock_select) begin
						// A toggle clears failure and reruns the timer;
						// the core stays on the internal source meanwhile.
						next_s.failCond = 1'b0;
						if (s.state != ST_SLEEP) begin
							next_s.state = ST_START;
							next_s.ostCnt = 11'h000;
						end
					end
				end
				`CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_FLAGS_2: begin
					// Clearing is refused while the failure is active.
					if (!s.wData[`CLOCK_FAIL_MONITOR_BIT_OSF] && !s.failCond) begin
						next_s.oscFailFlag = 1'b0;
					end
				end
				`CLOCK_FAIL_MONITOR_IDX_CFG: begin
					next_s.monEn = s.wData[`CLOCK_FAIL_MONITOR_BIT_MONEN];
					next_s.mode = s.wData[`CLOCK_FAIL_MONITOR_MODE_HI:`CLOCK_FAIL_MONITOR_MODE_LO];
				end
				`CLOCK_FAIL_MONITOR_IDX_PWR: begin
					next_s.sleepReq = s.wData[`CLOCK_FAIL_MONITOR_BIT_SLEEP];
				end
				default: begin
					next_s.bresp = `CLOCK_FAIL_MONITOR_RESP_SLVERR;
				end
			endcase
		end
		// A new failure sets the flag and wins over a clear.
		if (s.fs2 && armed) begin
			next_s.oscFailFlag = 1'b1;
		end

		// Read channel: the answer stands one cycle after the address.
		if (arvalid && arready) begin
			rdHit = (araddr[11:10] == 2'h0) && (araddr[1:0] == 2'h0);
			case (rdIdx)
				`CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_ENABLE_2: begin
					rdByte = {s.peripheral_irq_enable_2, 4'h0};
				end
				`CLOCK_FAIL_MONITOR_IDX_OSCILLATOR_CONTROL_REG: begin
					// Start-up status shows the external source is live.
					rdByte = {1'b0, s.internal_freq_select, 4'h0};
					rdByte[`CLOCK_FAIL_MONITOR_BIT_STARTUP_TIMEOUT_STATUS] = (s.state == ST_RUN) &&
						!s.failCond && !s.system_clock_select && extMode;
					rdByte[`CLOCK_FAIL_MONITOR_BIT_SCS] = s.system_clock_select;
				end
				`CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_FLAGS_2: begin
					rdByte[`CLOCK_FAIL_MONITOR_BIT_OSF] = s.oscFailFlag;
				end
				`CLOCK_FAIL_MONITOR_IDX_CFG: begin
					rdByte[`CLOCK_FAIL_MONITOR_BIT_MONEN] = s.monEn;
					rdByte[`CLOCK_FAIL_MONITOR_MODE_HI:`CLOCK_FAIL_MONITOR_MODE_LO] = s.mode;
				end
				`CLOCK_FAIL_MONITOR_IDX_PWR: begin
					rdByte[`CLOCK_FAIL_MONITOR_BIT_SLEEP] = s.sleepReq;
				end
				default: begin
					rdHit = 1'b0;
				end
			endcase
			next_s.rvalid = 1'b1;
			next_s.rdata = rdHit ? {24'h000000, rdByte} : 32'h00000000;
			next_s.rresp = rdHit ? `CLOCK_FAIL_MONITOR_RESP_OKAY : `CLOCK_FAIL_MONITOR_RESP_SLVERR;
		end else if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
	end

	// State register; a low clock enable freezes everything.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.state <= ST_START;
			s.internal_freq_select <= `CLOCK_FAIL_MONITOR_RST_INTERNAL_FREQ_SELECT;
			s.peripheral_irq_enable_2 <= `CLOCK_FAIL_MONITOR_RST_PERIPHERAL_IRQ_ENABLE_2;
			s.mode <= `CLOCK_FAIL_MONITOR_RST_MODE;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Clock source: internal in failure, during two-speed start-up,
	// when software selects it or when the mode has no external source.
	always_comb begin
		sysClkInternal = s.failCond || s.system_clock_select || !extMode ||
			(s.monEn && (s.state == ST_START));
		// Without the monitor the core waits for the start-up timer.
		coreHold = !s.monEn && extMode && !s.system_clock_select &&
			(s.state == ST_START);
	end

	assign intFreqSel = s.internal_freq_select;
	assign sleeping = (s.state == ST_SLEEP);
	assign oscFailIrq = s.oscFailFlag && s.peripheral_irq_enable_2[3];
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;

endmodule : clock_fail_monitor_top

//--- verif/clock_fail_monitor_osc_model.sv
// External oscillator model that can be stopped like a dead crystal.
`timescale 1ns/100ps

module clock_fail_monitor_osc_model #(
	parameter int HALF = 2
) (
	// Clock and run control.
	input wire logic clk,
	input wire logic run,
	// Oscillator level.
	output logic extClk
);
	// Cycles spent in the present half period.
	int cnt = 0;

	initial extClk = 1'b0;

	// A dead crystal rests stuck high, so no falling edge reaches the block.
	always @(posedge clk) begin
		if (!run) begin
			extClk <= 1'b1;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			extClk <= !extClk;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : clock_fail_monitor_osc_model

//--- verif/clock_fail_monitor_top_props.sv
// Assertion checker on the ports of the clock fail monitor.
`timescale 1ns/100ps
`include "clock_fail_monitor_consts.svh"

module clock_fail_monitor_top_props
	import clock_fail_monitor_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Oscillator levels.
	input wire logic extClk,
	input wire logic lfOsc,
	// Register bus.
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// Clock control outputs.
	input wire logic sysClkInternal,
	input wire logic [2:0] intFreqSel,
	input wire logic sleeping,
	input wire logic oscFailIrq
);
	// Slow oscillator rises since the last external falling edge.
	logic [6:0] lfSince;
	logic extPrev;
	logic lfPrev;
	// High when the read address names a register.
	logic rdOk;

	assign rdOk = araddr inside {{2'h0, `CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_ENABLE_2, 2'h0},
		{2'h0, `CLOCK_FAIL_MONITOR_IDX_OSCILLATOR_CONTROL_REG, 2'h0}, {2'h0, `CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_FLAGS_2, 2'h0},
		{2'h0, `CLOCK_FAIL_MONITOR_IDX_CFG, 2'h0}, {2'h0, `CLOCK_FAIL_MONITOR_IDX_PWR, 2'h0}};

	// The count saturates so a long dead spell never wraps to a small value.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			extPrev <= 1'b0;
			lfPrev <= 1'b0;
			lfSince <= 7'h00;
		end else begin
			extPrev <= extClk;
			lfPrev <= lfOsc;
			if (extPrev && !extClk) begin
				lfSince <= 7'h00;
			end else if (lfOsc && !lfPrev && lfSince != 7'h7F) begin
				lfSince <= lfSince + 7'h01;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer moved before taken");
	wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer moved before taken");
	wr_resp_a: assert property (ce && awvalid && awready && wvalid && wready
		|-> ##2 bvalid) else $error("write answer late");
	rd_resp_a: assert property (ce && arvalid && arready |=> rvalid)
		else $error("read answer late");
	rd_block_a: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	wr_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	unmapped_rd_a: assert property (arvalid && arready && !rdOk
		|=> rresp == `CLOCK_FAIL_MONITOR_RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read answered");
	upper_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	freq_write_a: assert property ($changed(intFreqSel) |-> $rose(bvalid))
		else $error("fallback frequency moved without write");
	// Waking from sleep starts two-speed start-up, which is no failover.
	no_false_fail_a: assert property ($rose(sysClkInternal) &&
		!$rose(bvalid) && !$past(sleeping)
		|-> lfSince >= 7'd31) else $error("failover before half sample");

	cover property ($rose(oscFailIrq));
	cover property ($rose(sysClkInternal) && !$rose(bvalid));
	cover property (rvalid && rresp == `CLOCK_FAIL_MONITOR_RESP_SLVERR);
endmodule : clock_fail_monitor_top_props

bind clock_fail_monitor_top clock_fail_monitor_top_props clock_fail_monitor_top_props_i (.*);

//--- verif/clock_fail_monitor_top_test.sv
// Self-checking bench of the clock fail monitor.
`timescale 1ns/100ps
`include "clock_fail_monitor_consts.svh"
`define CHK(n, e, g) begin \
	cmpCount++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("mismatch %s expected %0h seen %0h", n, e, g); \
	end \
end

module clock_fail_monitor_top_test
	import clock_fail_monitor_pkg::*;
;
	// Expected read answer; a zero mask with a zero expectation always passes the data compare.
	typedef struct {
		logic [31:0] e;
		logic [31:0] m;
		logic [1:0] r;
	} clock_fail_monitor_note_t;
	localparam logic [11:0] PIE = {2'h0, `CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_ENABLE_2, 2'h0};
	localparam logic [11:0] OSC = {2'h0, `CLOCK_FAIL_MONITOR_IDX_OSCILLATOR_CONTROL_REG, 2'h0};
	localparam logic [11:0] FLG = {2'h0, `CLOCK_FAIL_MONITOR_IDX_PERIPHERAL_IRQ_FLAGS_2, 2'h0};
	localparam logic [11:0] CFG = {2'h0, `CLOCK_FAIL_MONITOR_IDX_CFG, 2'h0};
	localparam logic [11:0] PWR = {2'h0, `CLOCK_FAIL_MONITOR_IDX_PWR, 2'h0};
	localparam logic [1:0] OK = `CLOCK_FAIL_MONITOR_RESP_OKAY;
	localparam logic [1:0] ERR = `CLOCK_FAIL_MONITOR_RESP_SLVERR;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, lfOsc = 1'b0, run = 1'b1;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [2:0] awprot = 3'h0, arprot = 3'h0, intFreqSel;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic extClk, awready, wready, bvalid, arready, rvalid;
	logic sysClkInternal, coreHold, sleeping, oscFailIrq;
	logic [1:0] bresp, rresp;
	int miscompares = 0, cmpCount = 0;
	clock_fail_monitor_note_t notes[$];
	clock_fail_monitor_note_t nt;

	clock_fail_monitor_top clock_fail_monitor_top_i (.*);
	clock_fail_monitor_osc_model clock_fail_monitor_osc_model_i (.clk(clk), .run(run), .extClk(extClk));

	// 200 MHz clock; the slow oscillator runs at half of it.
	always #2.5 clk = !clk;
	always @(posedge clk) lfOsc <= !lfOsc;

	// Each read answer is matched against the oldest noted expectation.
	always @(posedge clk) begin
		if (rvalid && rready && notes.size() > 0) begin
			nt = notes.pop_front();
			`CHK("rdata", nt.e, rdata & nt.m)
			`CHK("rresp", nt.r, rresp)
		end
	end

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// Write one word; address and data are offered together.
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1 | 4'($urandom);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge clk);
		while (!bvalid) begin
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			@(posedge clk);
		end
		`CHK("bresp", r, bresp)
		bready <= 1'b0;
	endtask : wr

	// Read one word and note the expected answer for the monitor.
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic [1:0] r, output logic [31:0] d);
		@(posedge clk);
		notes.push_back('{e, m, r});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge clk);
		while (!rvalid) begin
			if (arready) arvalid <= 1'b0;
			@(posedge clk);
		end
		d = rdata;
		rready <= 1'b0;
	endtask : rd

	// Poll the start-up status bit; the watchdog bounds the wait.
	task automatic wait_ready(output int polls);
		polls = 0;
		do begin
			rd(OSC, 32'h0, 32'h0, OK, rv);
			polls++;
		end while (!rv[`CLOCK_FAIL_MONITOR_BIT_STARTUP_TIMEOUT_STATUS]);
	endtask : wait_ready

	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
	endtask : do_reset

	initial begin
		int polls;
		logic [2:0] internal_freq_select;
		logic [3:0] pie;
		void'($urandom(88));
		do_reset();
		rd(OSC, 32'h60, 32'hF7, OK, rv);
		rd(PIE, 32'h0, 32'hFF, OK, rv);
		rd(12'h300, 32'h0, 32'hFFFFFFFF, ERR, rv);
		rd(12'h235, 32'h0, 32'hFFFFFFFF, ERR, rv);
		wr(12'h300, 8'hFF, ERR);
		$display("test reset values done");
		// Every external mode: arm, fail, recover by sleep or select toggle.
		for (int m = 0; m < 6; m++) begin
			run <= 1'b1;
			do_reset();
			internal_freq_select = 3'($urandom);
			pie = {1'b1, 3'($urandom)};
			wr(PIE, {pie, 4'h0}, OK);
			rd(PIE, {24'h0, pie, 4'h0}, 32'hFF, OK, rv);
			wr(OSC, {1'b0, internal_freq_select, 4'h0}, OK);
			`CHK("intFreqSel", internal_freq_select, intFreqSel)
			wr(CFG, {4'h0, 3'(m), 1'b1}, OK);
			wait_ready(polls);
			if (m > 2) `CHK("early arm", 1'b1, 1'(polls < 3))
			run <= 1'b0;
			repeat (600) if (!sysClkInternal) @(posedge clk);
			`CHK("internal clock", 1'b1, sysClkInternal)
			`CHK("irq", 1'b1, oscFailIrq)
			rd(FLG, 32'h80, 32'hFF, OK, rv);
			wr(FLG, 8'h00, OK);
			rd(FLG, 32'h80, 32'hFF, OK, rv);
			run <= 1'b1;
			repeat (300) @(posedge clk);
			`CHK("internal clock", 1'b1, sysClkInternal)
			if (m[0]) begin
				wr(PWR, 8'h01, OK);
				// The state moves one edge after the write lands.
				@(posedge clk);
				`CHK("sleeping", 1'b1, sleeping)
				wr(PWR, 8'h00, OK);
			end else begin
				wr(OSC, {1'b0, internal_freq_select, 4'h1}, OK);
				wr(OSC, {1'b0, internal_freq_select, 4'h0}, OK);
			end
			// Waking takes effect one edge after the write; a select toggle restart lands with the write.
			@(posedge clk);
			if (m < 3) `CHK("two speed", 1'b1, sysClkInternal)
			wait_ready(polls);
			`CHK("external clock", 1'b0, sysClkInternal)
			wr(FLG, 8'h00, OK);
			rd(FLG, 32'h0, 32'hFF, OK, rv);
			`CHK("irq", 1'b0, oscFailIrq)
			$display("test mode %0d done", m);
		end
		// Monitor fuse off: a dead crystal goes unnoticed.
		do_reset();
		wr(PIE, 8'h80, OK);
		wr(CFG, 8'h02, OK);
		`CHK("core hold", 1'b1, coreHold)
		wait_ready(polls);
		`CHK("core hold", 1'b0, coreHold)
		run <= 1'b0;
		repeat (600) @(posedge clk);
		`CHK("internal clock", 1'b0, sysClkInternal)
		rd(FLG, 32'h0, 32'hFF, OK, rv);
		$display("test monitor off done");
		report_and_stop();
	end

	// Watchdog sized well above the expected run of about 32000 cycles.
	initial begin
		#450000;
		miscompares++;
		report_and_stop();
	end
endmodule : clock_fail_monitor_top_test
